// File: dv/cr_writer_model.sv
/*
 Model of the pipeline stage that writes condition bits.
 Assumes one write in flight at a time, each request a one-cycle pulse.
*/
module cr_writer_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic set_i,
    input wire logic [4:0] set_idx_i,
    input wire logic set_val_i,
    input wire logic [3:0] set_delay_i,
    output logic [31:0] condition_register_o,
    output logic [31:0] cr_pending_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;
    logic [4:0] idx_q;
    logic val_q;

    // Zero delay writes at once; else the bit stays flagged until written
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            condition_register_o <= 32'h0000_0000;
            cr_pending_o <= 32'h0000_0000;
            cnt <= 4'h0;
        end else if (set_i && set_delay_i == 4'h0) begin
            condition_register_o[set_idx_i] <= set_val_i;
        end else if (set_i) begin
            cr_pending_o[set_idx_i] <= 1'b1;
            cnt <= set_delay_i;
            idx_q <= set_idx_i;
            val_q <= set_val_i;
        end else if (cnt == 4'h1) begin
            // Flag drops in the same cycle the value shows
            condition_register_o[idx_q] <= val_q;
            cr_pending_o[idx_q] <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
endmodule : cr_writer_model

// File: dv/tb_top.sv
/*
 Testbench for the branch resolve and predict block.
 Assumes the condition writer model drives the condition inputs.
*/
module tb_top
    import branch_resolve_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_i, rst_i, dec_valid_i, dyn_predict_en_i;
    logic [31:0] decode_pc_i, decode_insn_i, count_register_i, link_return_register_i;
    logic [31:0] condition_register_i, cr_pending_i, fetch_addr_o, link_wdata_o, ctr_wdata_o;
    logic set_i, set_val_i;
    logic [4:0] set_idx_i;
    logic [3:0] set_delay_i;
    logic decode_ready_o, fetch_redirect_o, flush_o, speculative_o, predict_taken_o;
    logic resolve_o, resolve_taken_o, link_wr_o, ctr_wr_o;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    branch_resolve_predict_count_target branch_resolve_predict_count_target_inst (
        .core_clk_i, .rst_i, .dec_valid_i, .decode_pc_i, .decode_insn_i,
        .condition_register_i, .cr_pending_i, .count_register_i, .link_return_register_i,
        .dyn_predict_en_i, .decode_ready_o, .fetch_redirect_o, .fetch_addr_o, .flush_o,
        .speculative_o, .predict_taken_o, .resolve_o, .resolve_taken_o, .link_wr_o,
        .link_wdata_o, .ctr_wr_o, .ctr_wdata_o);

    cr_writer_model cr_writer_model_inst (
        .core_clk_i, .rst_i, .set_i, .set_idx_i, .set_val_i, .set_delay_i,
        .condition_register_o(condition_register_i), .cr_pending_o(cr_pending_i));

    // 125 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end

    // Ceiling well above the hundred or so cycles the tests need
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            $display("ERROR cycle limit expected done seen running");
            results();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic chk1(input string name, input logic exp, input logic got);
        chk(name, {31'h0, exp}, {31'h0, got});
    endtask : chk1

    task automatic results();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    // Displacement form and count-register form encoders
    function automatic logic [31:0] bc(input logic [4:0] opt, sel, input logic [13:0] d,
                                       input logic aa);
        return {OPC_BCOND, opt, sel, d, aa, 1'b0};
    endfunction : bc

    function automatic logic [31:0] bcc(input logic [4:0] opt, sel, input logic link_bit);
        return {OPC_XL, opt, sel, 5'h00, XO_TO_COUNT, link_bit};
    endfunction : bcc

    // Ask the writer model for a condition bit, now or after a delay
    task automatic cr_set(input logic [4:0] idx, input logic val, input logic [3:0] dly);
        @(posedge core_clk_i);
        set_i <= 1'b1;
        set_idx_i <= idx;
        set_val_i <= val;
        set_delay_i <= dly;
        @(posedge core_clk_i);
        set_i <= 1'b0;
    endtask : cr_set

    // One-cycle decode request; returns just after the first answer edge
    task automatic dec(input logic [31:0] pc, input logic [31:0] insn);
        @(posedge core_clk_i);
        dec_valid_i <= 1'b1;
        decode_pc_i <= pc;
        decode_insn_i <= insn;
        @(posedge core_clk_i);
        dec_valid_i <= 1'b0;
        // Pulses launched at the taking edge stand for this cycle only
        #1;
    endtask : dec

    // Branch resolved at decode
    task automatic res(input logic [31:0] pc, insn, input logic tk, input logic [31:0] tgt);
        dec(pc, insn);
        chk1("resolve_o", 1'b1, resolve_o);
        chk1("resolve_taken_o", tk, resolve_taken_o);
        chk1("fetch_redirect_o", tk, fetch_redirect_o);
        chk1("flush_o", 1'b0, flush_o);
        chk1("decode_ready_o", 1'b1, decode_ready_o);
        if (tk) begin
            chk("fetch_addr_o", tgt, fetch_addr_o);
        end
    endtask : res

    // Branch held by a pending writer: prediction, then resolution
    task automatic unres(input logic [31:0] pc, insn, input logic pr, tk,
                         input logic [31:0] tgt);
        int n;
        n = 0;
        dec(pc, insn);
        chk1("speculative_o", 1'b1, speculative_o);
        chk1("decode_ready_o", 1'b0, decode_ready_o);
        @(posedge core_clk_i);
        #1;
        chk1("predict_taken_o", pr, predict_taken_o);
        chk1("fetch_redirect_o", pr, fetch_redirect_o);
        if (pr) begin
            chk("fetch_addr_o", tgt, fetch_addr_o);
        end
        while (resolve_o !== 1'b1 && n < 30) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        chk1("resolve_o", 1'b1, resolve_o);
        chk1("resolve_taken_o", tk, resolve_taken_o);
        chk1("flush_o", pr ^ tk, flush_o);
        chk1("fetch_redirect_o", pr ^ tk, fetch_redirect_o);
        if (pr ^ tk) begin
            chk("fetch_addr_o", tk ? tgt : pc + INSN_BYTES, fetch_addr_o);
        end
        chk1("speculative_o", 1'b0, speculative_o);
    endtask : unres

    // Main sequence
    initial begin
        rst_i = 1'b1;
        dec_valid_i = 1'b0;
        dyn_predict_en_i = 1'b0;
        decode_pc_i = 32'h0000_0000;
        decode_insn_i = 32'h0000_0000;
        count_register_i = 32'h1234_5677;
        link_return_register_i = 32'h0000_ABC0;
        set_i = 1'b0;
        set_idx_i = 5'h00;
        set_val_i = 1'b0;
        set_delay_i = 4'h0;
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        // Count loaded long before the branch that uses it
        res(32'h0000_1000, bcc(5'h14, 5'h00, 1'b1), 1'b1, 32'h1234_5674);
        chk1("link_wr_o", 1'b1, link_wr_o);
        chk("link_wdata_o", 32'h0000_1004, link_wdata_o);
        chk1("ctr_wr_o", 1'b0, ctr_wr_o);
        // Link form: target from the link value, link rewritten
        res(32'h0000_A000, {OPC_XL, 5'h14, 5'h00, 5'h00, XO_TO_LINK, 1'b1}, 1'b1,
            32'h0000_ABC0);
        chk("link_wdata_o", 32'h0000_A004, link_wdata_o);
        $display("test count_link done");
        // Both test polarities against both bit values
        for (int i = 0; i < 4; i++) begin
            cr_set(5'h0A, i[0], 4'h0);
            res(32'h0000_2000, bcc({1'b0, i[1], 3'b100}, 5'h0A, 1'b0), i[0] == i[1],
                32'h1234_5674);
            chk1("link_wr_o", 1'b0, link_wr_o);
        end
        $display("test cond_bit done");
        // Count decrement decides the displacement branch
        for (int i = 1; i < 3; i++) begin
            @(posedge core_clk_i);
            count_register_i <= 32'(i);
            res(32'h0000_3000, bc(5'h10, 5'h00, 14'h0010, 1'b0), i == 2,
                32'h0000_3040);
            chk1("ctr_wr_o", 1'b1, ctr_wr_o);
            chk("ctr_wdata_o", 32'(i - 1), ctr_wdata_o);
        end
        $display("test count_dec done");
        // Backward branch with reversal bit clear, then wrong
        cr_set(5'h03, 1'b0, 4'h8);
        unres(32'h0000_5000, bc(5'h0C, 5'h03, 14'h3FF0, 1'b0), 1'b1, 1'b0,
              32'h0000_4FC0);
        cr_set(5'h04, 1'b1, 4'h8);
        unres(32'h0000_6000, bc(5'h0D, 5'h04, 14'h0008, 1'b0), 1'b1, 1'b1,
              32'h0000_6020);
        @(posedge core_clk_i);
        count_register_i <= 32'h0000_7777;
        cr_set(5'h05, 1'b0, 4'h8);
        unres(32'h0000_7000, bcc(5'h0C, 5'h05, 1'b0), 1'b0, 1'b0, 32'h0000_7774);
        cr_set(5'h06, 1'b1, 4'h8);
        unres(32'h0000_8000, bc(5'h0C, 5'h06, 14'h3FF0, 1'b1), 1'b1, 1'b1,
              32'hFFFF_FFC0);
        $display("test static_predict done");
        // Untouched history entry overrides the backward sign
        @(posedge core_clk_i);
        dyn_predict_en_i <= 1'b1;
        cr_set(5'h07, 1'b1, 4'h8);
        unres(32'h0000_9004, bc(5'h0C, 5'h07, 14'h3FF0, 1'b0), 1'b0, 1'b1,
              32'h0000_8FC4);
        $display("test dynamic_predict done");
        results();
    end
endmodule : tb_top

// File: logic/branch_history_mem.sv
/*
 Branch history table: two-bit counters, one read and one write port.
 Read data come from a register, so a lookup answers one cycle later.
*/
module branch_history_mem
    import branch_resolve_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [HIST_AW-1:0] rd_idx_i,
    output logic [1:0] rd_cnt_o,
    input wire logic wr_en_i,
    input wire logic [HIST_AW-1:0] wr_idx_i,
    input wire logic [1:0] wr_cnt_i
);
    logic [1:0] cnt_mem [HIST_DEPTH];

    // Counters start weakly not taken
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < HIST_DEPTH; i++) begin
                cnt_mem[i] <= HIST_RESET;
            end
        end else if (wr_en_i) begin
            cnt_mem[wr_idx_i] <= wr_cnt_i;
        end
    end

    // Registered read port
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_cnt_o <= HIST_RESET;
        end else begin
            rd_cnt_o <= cnt_mem[rd_idx_i];
        end
    end
endmodule : branch_history_mem

// File: logic/branch_resolve_pkg.sv
/*
 Constants, field positions, states and helper functions for the
 branch resolve and predict block. Assumes big-endian instruction bit
 numbering mapped onto a [31:0] word, bit 0 of the encoding at [31].
*/
package branch_resolve_pkg;
    // Primary and extended opcodes
    localparam logic [5:0] OPC_BCOND = 6'h10;
    localparam logic [5:0] OPC_XL = 6'h13;
    localparam logic [9:0] XO_TO_LINK = 10'h010;
    localparam logic [9:0] XO_TO_COUNT = 10'h210;
    // Instruction field positions
    localparam int OPC_HI = 31;
    localparam int OPC_LO = 26;
    localparam int OPT_HI = 25;
    localparam int OPT_LO = 21;
    localparam int SEL_HI = 20;
    localparam int SEL_LO = 16;
    localparam int DISP_HI = 15;
    localparam int DISP_LO = 2;
    localparam int SIGN_POS = 15;
    localparam int XO_HI = 10;
    localparam int XO_LO = 1;
    localparam int ABS_POS = 1;
    localparam int LINK_POS = 0;
    // Options field bits, little-endian inside the 5-bit field
    localparam int OPT_CR_SKIP = 4;
    localparam int OPT_CR_VAL = 3;
    localparam int OPT_CTR_SKIP = 2;
    localparam int OPT_CTR_VAL = 1;
    localparam int OPT_REVERSE = 0;
    // Sizes and reset values
    localparam logic [31:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
    localparam int HIST_AW = 4;
    localparam int HIST_DEPTH = 16;
    localparam logic [1:0] HIST_RESET = 2'h1;
    localparam logic [1:0] HIST_MAX = 2'h3;
    localparam logic [1:0] HIST_MIN = 2'h0;

    typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_WAIT} br_state_t;

    // Clears the two low-order address bits
    function automatic logic [31:0] word_align(input logic [31:0] a);
        return {a[31:2], 2'h0};
    endfunction : word_align

    // Default prediction with reversal; branch-always cannot be reversed
    function automatic logic predict_static(input logic [4:0] opt, input logic s);
        logic always_tk;
        always_tk = opt[OPT_CR_SKIP] & opt[OPT_CTR_SKIP];
        return always_tk | (s ^ opt[OPT_REVERSE]);
    endfunction : predict_static

    // Two-bit saturating history update
    function automatic logic [1:0] hist_step(input logic [1:0] c, input logic tk);
        if (tk) begin
            return (c == HIST_MAX) ? c : 2'(c + 2'h1);
        end
        return (c == HIST_MIN) ? c : 2'(c - 2'h1);
    endfunction : hist_step
endpackage : branch_resolve_pkg

// File: logic/branch_resolve_predict_count_target.sv
/*
 Branch resolution and prediction for conditional branches, with the
 count-register target form and link update. Assumes the pipeline
 flags condition bits with a writer in flight on cr_pending_i and clears a
 flag in the cycle its result is visible on condition_register_i.
*/
// Operation
// - count-register target, low two bits cleared
// - linking form writes next address to link
// - test condition bit chosen by select index
// - taken goes to target, else sequential
// - check in-flight writers, resolve at once if none
// - hold unresolved until writer updates condition bits
// - fetch from predicted path after prediction
// - mispredict discards path and restarts fetch
// - correct prediction causes no flush or restart
// - displacement target computed before resolution
// - predict taken when sign or always-branch
// - sign taken from encoding bit sixteen
// - not-taken prediction fetches sequential instructions
// - link and count forms use zero sign
// - reversal bit inverts default prediction
// - branch-always predicted taken, reversal ignored
// - sign used even with absolute target
// - options bit two skips count decrement and test
// - options bit zero skips condition test
module branch_resolve_predict_count_target
    import branch_resolve_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic dec_valid_i,
    input wire logic [31:0] decode_pc_i,
    input wire logic [31:0] decode_insn_i,
    input wire logic [31:0] condition_register_i,
    input wire logic [31:0] cr_pending_i,
    input wire logic [31:0] count_register_i,
    input wire logic [31:0] link_return_register_i,
    input wire logic dyn_predict_en_i,
    output logic decode_ready_o,
    output logic fetch_redirect_o,
    output logic [31:0] fetch_addr_o,
    output logic flush_o,
    output logic speculative_o,
    output logic predict_taken_o,
    output logic resolve_o,
    output logic resolve_taken_o,
    output logic link_wr_o,
    output logic [31:0] link_wdata_o,
    output logic ctr_wr_o,
    output logic [31:0] ctr_wdata_o
);
    br_state_t state;
    logic [5:0] opc;
    logic [9:0] xo;
    logic [4:0] opt;
    logic [4:0] sel;
    logic is_disp, is_to_link, is_to_count, dec_fire;
    logic sign_bit, unresolved, cr_ok, ctr_ok, taken_now, static_pred;
    logic [31:0] disp_ext, target, seq_addr, ctr_dec;
    logic [31:0] h_target, h_seq;
    logic [4:0] h_sel;
    logic h_cr_skip, h_cr_val, h_ctr_ok, h_static, h_always;
    logic [HIST_AW-1:0] h_idx, rd_idx;
    logic [1:0] hist_cnt, h_cnt;
    logic pred_now, outcome, wait_done;

    // One branch in flight; a second waits for resolution
    assign decode_ready_o = (state == ST_IDLE);

    // Field decode
    assign opc = decode_insn_i[OPC_HI:OPC_LO];
    assign xo = decode_insn_i[XO_HI:XO_LO];
    assign opt = decode_insn_i[OPT_HI:OPT_LO];
    assign sel = decode_insn_i[SEL_HI:SEL_LO];
    assign is_disp = (opc == OPC_BCOND);
    assign is_to_link = (opc == OPC_XL) && (xo == XO_TO_LINK);
    assign is_to_count = (opc == OPC_XL) && (xo == XO_TO_COUNT);
    assign dec_fire = dec_valid_i && decode_ready_o && (is_disp || is_to_link || is_to_count);

    // Target formed at decode, ahead of the condition
    assign disp_ext = {{16{decode_insn_i[SIGN_POS]}}, decode_insn_i[DISP_HI:DISP_LO], 2'h0};
    assign seq_addr = 32'(decode_pc_i + INSN_BYTES);
    always_comb begin
        if (is_disp) begin
            // Absolute flag picks the bare displacement
            target = decode_insn_i[ABS_POS] ? disp_ext : 32'(decode_pc_i + disp_ext);
        end else if (is_to_count) begin
            target = word_align(count_register_i);
        end else begin
            target = word_align(link_return_register_i);
        end
    end

    // Condition evaluation
    assign ctr_dec = 32'(count_register_i - 32'h0000_0001);
    // Count form cannot decrement; treated as count untested
    assign ctr_ok = opt[OPT_CTR_SKIP] | is_to_count
        | ((ctr_dec != 32'h0000_0000) ^ opt[OPT_CTR_VAL]);
    assign cr_ok = opt[OPT_CR_SKIP] | (condition_register_i[sel] == opt[OPT_CR_VAL]);
    assign taken_now = cr_ok && ctr_ok;
    assign unresolved = !opt[OPT_CR_SKIP] && cr_pending_i[sel];

    // Sign only exists for the displacement form, absolute or not
    assign sign_bit = is_disp & decode_insn_i[SIGN_POS];
    assign static_pred = predict_static(opt, sign_bit);

    // History lookup: decode index in idle, held index afterwards
    assign rd_idx = (state == ST_IDLE) ? decode_pc_i[HIST_AW+1:2] : h_idx;
    // Always-branch ignores history and reversal alike
    assign pred_now = h_always | (dyn_predict_en_i ? hist_cnt[1] : h_static);
    assign wait_done = (state == ST_WAIT) && !cr_pending_i[h_sel];
    assign outcome = h_ctr_ok && (h_cr_skip || condition_register_i[h_sel] == h_cr_val);

    branch_history_mem u_hist (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .rd_idx_i(rd_idx),
        .rd_cnt_o(hist_cnt),
        .wr_en_i(wait_done),
        .wr_idx_i(h_idx),
        .wr_cnt_i(hist_step(h_cnt, outcome))
    );

    // Sequencer
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (dec_fire && unresolved) begin
                        state <= ST_LOOKUP;
                    end
                end
                ST_LOOKUP: begin
                    state <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (wait_done) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Branch context held while unresolved
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            h_target <= ADDR_RESET;
            h_seq <= ADDR_RESET;
            h_sel <= 5'h00;
            h_cr_skip <= 1'b0;
            h_cr_val <= 1'b0;
            h_ctr_ok <= 1'b0;
            h_static <= 1'b0;
            h_always <= 1'b0;
            h_idx <= '0;
            h_cnt <= HIST_RESET;
        end else if (dec_fire) begin
            h_target <= target;
            h_seq <= seq_addr;
            h_sel <= sel;
            h_cr_skip <= opt[OPT_CR_SKIP];
            h_cr_val <= opt[OPT_CR_VAL];
            h_ctr_ok <= ctr_ok;
            h_static <= static_pred;
            h_always <= opt[OPT_CR_SKIP] & opt[OPT_CTR_SKIP];
            h_idx <= decode_pc_i[HIST_AW+1:2];
        end else if (state == ST_LOOKUP) begin
            h_cnt <= hist_cnt;
        end
    end

    // Fetch steering, prediction and flush
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            fetch_redirect_o <= 1'b0;
            fetch_addr_o <= ADDR_RESET;
            flush_o <= 1'b0;
            predict_taken_o <= 1'b0;
        end else begin
            fetch_redirect_o <= 1'b0;
            flush_o <= 1'b0;
            if (dec_fire && !unresolved && taken_now) begin
                // Resolved taken; not taken just keeps fetching on
                fetch_redirect_o <= 1'b1;
                fetch_addr_o <= target;
            end else if (state == ST_LOOKUP) begin
                predict_taken_o <= pred_now;
                // Predicted not taken: sequential fetch carries on
                if (pred_now) begin
                    fetch_redirect_o <= 1'b1;
                    fetch_addr_o <= h_target;
                end
            end else if (wait_done && outcome != predict_taken_o) begin
                // Wrong path dropped, fetch restarts on the right one
                flush_o <= 1'b1;
                fetch_redirect_o <= 1'b1;
                fetch_addr_o <= outcome ? h_target : h_seq;
            end
        end
    end

    // Resolution report and speculation window
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            resolve_o <= 1'b0;
            resolve_taken_o <= 1'b0;
            speculative_o <= 1'b0;
        end else begin
            resolve_o <= (dec_fire && !unresolved) || wait_done;
            if (dec_fire && !unresolved) begin
                resolve_taken_o <= taken_now;
            end else if (wait_done) begin
                resolve_taken_o <= outcome;
            end
            // Pipeline holds commits while this is high
            if (dec_fire && unresolved) begin
                speculative_o <= 1'b1;
            end else if (wait_done) begin
                speculative_o <= 1'b0;
            end
        end
    end

    // Link and count updates; the branch itself is never speculative
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            link_wr_o <= 1'b0;
            link_wdata_o <= ADDR_RESET;
            ctr_wr_o <= 1'b0;
            ctr_wdata_o <= ADDR_RESET;
        end else begin
            link_wr_o <= dec_fire && decode_insn_i[LINK_POS];
            ctr_wr_o <= dec_fire && !opt[OPT_CTR_SKIP] && !is_to_count;
            if (dec_fire) begin
                link_wdata_o <= seq_addr;
                ctr_wdata_o <= ctr_dec;
            end
        end
    end

    // Checks
    sequence s_unres;
        dec_fire && unresolved;
    endsequence
    sequence s_predicted;
        (state == ST_LOOKUP) ##1 (state == ST_WAIT && speculative_o);
    endsequence

    chk_count_target: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_fire && is_to_count && !unresolved && taken_now |=> fetch_redirect_o
        && fetch_addr_o == {$past(count_register_i[31:2]), 2'h0})
        else $error("count target wrong");
    chk_link_write: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_fire && decode_insn_i[LINK_POS] |=> link_wr_o
        && link_wdata_o == 32'($past(decode_pc_i) + INSN_BYTES))
        else $error("link update wrong");
    chk_unres_path: assert property (@(posedge core_clk_i) disable iff (rst_i)
        s_unres |=> s_predicted)
        else $error("unresolved branch not predicted");
    chk_hold_pending: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state == ST_WAIT && cr_pending_i[h_sel] |=> !resolve_o && state == ST_WAIT)
        else $error("resolved while writer pending");
    chk_static_pred: assert property (@(posedge core_clk_i) disable iff (rst_i)
        (s_unres and !dyn_predict_en_i) ##1 !dyn_predict_en_i
        |=> predict_taken_o == $past(static_pred, 2))
        else $error("static prediction wrong");
    chk_mispredict: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wait_done && outcome != predict_taken_o |=> flush_o && fetch_redirect_o
        && !speculative_o)
        else $error("mispredict not flushed");
    chk_correct_pred: assert property (@(posedge core_clk_i) disable iff (rst_i)
        wait_done && outcome == predict_taken_o |=> !flush_o && !fetch_redirect_o)
        else $error("correct prediction disturbed fetch");
    chk_count_dec: assert property (@(posedge core_clk_i) disable iff (rst_i)
        dec_fire |=> ctr_wr_o == !($past(opt[OPT_CTR_SKIP]) || $past(is_to_count)))
        else $error("count decrement wrong");
endmodule : branch_resolve_predict_count_target
